// [shared/cbr_pkg.sv]
// constants, register map and carrier types for the bulk report mapper
// assumes a 100 MHz system clock and an internal register space
// reached through a simple read port with a one-cycle answer
//
// Contract
// - four independent bulk report blocks, each with its own four settings.
// - a block whose start address is zero sends nothing.
// - read the per-element enable register; send only when it is nonzero.
// - advance data and enable addresses by the stride between reads.
// - each block reads exactly its configured count of elements.
// - block 0 identifiers start at the base identifier plus 64.
// - each block starts where the previous block's identifiers ended.
// - element i reads start plus i times stride, identifier first plus i.
// - bulk frames share the individual report frame format exactly.
// - no messages unless the reporting enable flag is one; checked only in ST_IDLE and ST_NEXT, so an element in flight is still pushed.
// - repeat the whole sequence once per reporting period.
// - pause the configured microseconds between consecutive messages.
package cbr_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned US_NS = 1000;
   localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
   localparam int unsigned CYC_PER_US = US_NS / CLK_NS;
   localparam int unsigned N_BLOCKS = 4;
   localparam logic [10:0] BULK_ID_OFFSET = 11'h040;
   localparam int unsigned FIFO_DEPTH = 16;
   // register byte addresses; block n settings at BLK_BASE + 16*n
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BASE_ID = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_MSG_GAP = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_BLK_BASE = 8'h40;
   localparam logic [7:0] ADDR_BLK_END = 8'h80;
   localparam logic [7:0] BLK_SPAN = 8'h10;
   localparam logic [3:0] FLD_START = 4'h0;
   localparam logic [3:0] FLD_ENABLE = 4'h4;
   localparam logic [3:0] FLD_STRIDE = 4'h8;
   localparam logic [3:0] FLD_COUNT = 4'hc;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam logic [10:0] RST_BASE_ID = 11'h100;
   localparam logic [31:0] RST_PERIOD = 32'h0007a120;
   localparam logic [31:0] RST_MSG_GAP = 32'h000003e8;
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
   localparam logic [3:0] CAN_DLC = 4'h4;

   typedef struct packed {
      logic [10:0] ident;
      logic [3:0] dlc;
      logic [31:0] data;
   } cbr_frame_t;

   typedef struct packed {
      logic [31:0] start_addr;
      logic [31:0] enable_addr;
      logic [31:0] stride;
      logic [31:0] count;
   } cbr_block_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_NEXT = 3'b001,
      ST_RD_EN = 3'b011,
      ST_RD_DATA = 3'b010,
      ST_PUSH = 3'b110,
      ST_GAP = 3'b111
   } cbr_state_t;
endpackage

// [rtl/cbr_fifo.sv]
// synchronous FIFO with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module cbr_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   wire logic push;
   wire logic pop;
   wire logic full;
   wire logic empty;
   assign full = (cnt_reg == (AW+1)'(DEPTH));
   assign empty = (cnt_reg == '0);
   assign push = i_in_valid && !full;
   assign pop = i_out_ready && !empty;
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem_reg[rd_ptr_reg];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         end
         if (pop) begin
            rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
         end
         cnt_reg <= (AW+1)'(cnt_reg + push - pop);
      end
   end
endmodule
`default_nettype wire

// [rtl/cbr_mapper.sv]
// bulk report sequencer: Avalon-MM slave for settings, internal register
// read port, and a frame stream toward the CAN transmitter via a FIFO
// assumes the register space answers a read one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cbr_mapper
   import cbr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // internal register read port
   output logic o_reg_rd,
   output logic [31:0] o_reg_addr,
   input wire logic [31:0] i_reg_rdata,
   // frame stream to the CAN transmitter
   output logic o_frame_valid,
   input wire logic i_frame_ready,
   output cbr_frame_t o_frame
);
   logic ctrl_en_reg;
   logic [10:0] base_id_reg;
   logic [31:0] period_reg;
   logic [31:0] gap_reg;
   cbr_block_cfg_t cfg_reg [N_BLOCKS];

   cbr_state_t state_reg;
   cbr_state_t state_next;
   logic [1:0] blk_reg;
   logic [31:0] idx_reg;
   logic [10:0] id_reg;
   logic [31:0] dat_addr_reg;
   logic [31:0] en_addr_reg;
   logic [31:0] period_cnt_reg;
   logic [6:0] gap_cyc_reg;
   logic [31:0] gap_cnt_reg;
   logic [6:0] tick_cnt_reg;
   logic pend_reg;
   logic data_held_reg;
   logic suppressed_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   cbr_frame_t frame_reg;
   logic [31:0] msg_total_reg;

   // bus decode
   wire logic bus_req;
   wire logic in_blk;
   wire logic [1:0] acc_blk;
   wire logic [3:0] acc_fld;
   wire logic [31:0] be_mask;
   wire logic wr_now;
   assign bus_req = (i_avs_read || i_avs_write) && !ack_reg;
   assign in_blk = (i_avs_address >= ADDR_BLK_BASE) &&
      (i_avs_address < ADDR_BLK_END);
   assign acc_blk = i_avs_address[5:4];
   assign acc_fld = i_avs_address[3:0];
   assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wr_now = i_avs_write && ack_reg;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
   assign o_avs_readdata = rdata_reg;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = UNMAPPED_DATA;
      if (in_blk) begin
         case (acc_fld)
            FLD_START: rd_mux = cfg_reg[acc_blk].start_addr;
            FLD_ENABLE: rd_mux = cfg_reg[acc_blk].enable_addr;
            FLD_STRIDE: rd_mux = cfg_reg[acc_blk].stride;
            FLD_COUNT: rd_mux = cfg_reg[acc_blk].count;
            default: rd_mux = UNMAPPED_DATA;
         endcase
      end else begin
         case (i_avs_address)
            ADDR_CTRL: rd_mux = {31'h0, ctrl_en_reg};
            ADDR_BASE_ID: rd_mux = {21'h0, base_id_reg};
            ADDR_PERIOD: rd_mux = period_reg;
            ADDR_MSG_GAP: rd_mux = gap_reg;
            ADDR_STATUS: rd_mux = {msg_total_reg[27:0], 1'b0,
               suppressed_reg, blk_reg};
            default: rd_mux = UNMAPPED_DATA;
         endcase
      end
   end

   // one wait cycle on every access, answer in the second cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= bus_req;
         if (bus_req && i_avs_read) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl_en_reg <= 1'b0;
         base_id_reg <= RST_BASE_ID;
         period_reg <= RST_PERIOD;
         gap_reg <= RST_MSG_GAP;
         for (int b = 0; b < N_BLOCKS; b++) begin
            cfg_reg[b] <= '0;
         end
      end else if (wr_now) begin
         if (in_blk) begin
            case (acc_fld)
               FLD_START: cfg_reg[acc_blk].start_addr <= merge(
                  cfg_reg[acc_blk].start_addr, i_avs_writedata, be_mask);
               FLD_ENABLE: cfg_reg[acc_blk].enable_addr <= merge(
                  cfg_reg[acc_blk].enable_addr, i_avs_writedata, be_mask);
               FLD_STRIDE: cfg_reg[acc_blk].stride <= merge(
                  cfg_reg[acc_blk].stride, i_avs_writedata, be_mask);
               FLD_COUNT: cfg_reg[acc_blk].count <= merge(
                  cfg_reg[acc_blk].count, i_avs_writedata, be_mask);
               default: ;
            endcase
         end else begin
            case (i_avs_address)
               ADDR_CTRL: if (i_avs_byteenable[0]) begin
                  ctrl_en_reg <= i_avs_writedata[CTRL_EN_BIT];
               end
               ADDR_BASE_ID: base_id_reg <= 11'(merge({21'h0, base_id_reg},
                  i_avs_writedata, be_mask));
               ADDR_PERIOD: period_reg <= merge(period_reg,
                  i_avs_writedata, be_mask);
               ADDR_MSG_GAP: gap_reg <= merge(gap_reg, i_avs_writedata,
                  be_mask);
               default: ;
            endcase
         end
      end
   end

   // microsecond tick for the reporting period
   wire logic us_tick;
   assign us_tick = (tick_cnt_reg == 7'(CYC_PER_US - 1));
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= us_tick ? 7'h00 : 7'(tick_cnt_reg + 1'b1);
      end
   end

   // period counter raises a pending sweep request
   wire logic period_hit;
   assign period_hit = us_tick && (period_cnt_reg + 32'h1 >= period_reg);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         period_cnt_reg <= '0;
      end else if (period_hit) begin
         period_cnt_reg <= '0;
      end else if (us_tick) begin
         period_cnt_reg <= period_cnt_reg + 32'h1;
      end
   end

   // a hit during a sweep is kept and starts the next sweep from idle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pend_reg <= 1'b0;
      end else if (period_hit && ctrl_en_reg) begin
         pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
         pend_reg <= 1'b0;
      end
   end

   // sequencer
   wire cbr_block_cfg_t cur;
   wire logic blk_done;
   wire logic blk_skip;
   wire logic last_blk;
   wire logic fifo_ready;
   wire logic gap_done;
   wire logic push_req;
   wire logic gap_us_end;
   assign cur = cfg_reg[blk_reg];
   assign blk_done = (idx_reg >= cur.count);
   assign blk_skip = (cur.start_addr == '0);
   assign last_blk = (blk_reg == 2'(N_BLOCKS - 1));
   assign gap_done = (gap_cnt_reg >= gap_reg);
   assign push_req = (state_reg == ST_PUSH) && data_held_reg;
   assign gap_us_end = (gap_cyc_reg == 7'(CYC_PER_US - 1));

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (pend_reg && ctrl_en_reg) begin
            state_next = ST_NEXT;
         end
         ST_NEXT: if (!ctrl_en_reg) begin
            state_next = ST_IDLE;
         end else if (blk_done || blk_skip) begin
            state_next = last_blk ? ST_IDLE : ST_NEXT;
         end else begin
            state_next = ST_RD_EN;
         end
         ST_RD_EN: state_next = ST_RD_DATA;
         ST_RD_DATA: state_next = (i_reg_rdata != '0) ? ST_PUSH : ST_NEXT;
         ST_PUSH: if (push_req && fifo_ready) begin
            state_next = ST_GAP;
         end
         ST_GAP: if (gap_done) begin
            state_next = ST_NEXT;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= ST_IDLE;
         blk_reg <= '0;
         idx_reg <= '0;
         id_reg <= '0;
         dat_addr_reg <= '0;
         en_addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         case (state_reg)
            ST_IDLE: begin
               blk_reg <= '0;
               idx_reg <= '0;
               id_reg <= base_id_reg + BULK_ID_OFFSET;
               dat_addr_reg <= cfg_reg[0].start_addr;
               en_addr_reg <= cfg_reg[0].enable_addr;
            end
            ST_NEXT: if (blk_done || blk_skip) begin
               // next block starts after this block's full id range
               id_reg <= 11'(id_reg + cur.count - idx_reg);
               blk_reg <= 2'(blk_reg + 1'b1);
               idx_reg <= '0;
               dat_addr_reg <= cfg_reg[2'(blk_reg + 1'b1)].start_addr;
               en_addr_reg <= cfg_reg[2'(blk_reg + 1'b1)].enable_addr;
            end
            ST_RD_DATA: begin
               // suppressed or not, the element uses its id slot
               id_reg <= 11'(id_reg + 1'b1);
               idx_reg <= idx_reg + 32'h1;
               dat_addr_reg <= dat_addr_reg + cur.stride;
               en_addr_reg <= en_addr_reg + cur.stride;
            end
            default: ;
         endcase
      end
   end

   // header and enable verdict are taken at the data read; the payload
   // arrives one cycle later, in the first push cycle, and the frame is
   // offered to the fifo from the second push cycle on
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         frame_reg <= '0;
         suppressed_reg <= 1'b0;
         data_held_reg <= 1'b0;
      end else if (state_reg == ST_RD_DATA) begin
         frame_reg.ident <= id_reg;
         frame_reg.dlc <= CAN_DLC;
         suppressed_reg <= (i_reg_rdata == '0);
         data_held_reg <= 1'b0;
      end else if ((state_reg == ST_PUSH) && !data_held_reg) begin
         frame_reg.data <= i_reg_rdata;
         data_held_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         msg_total_reg <= '0;
      end else if (push_req && fifo_ready) begin
         msg_total_reg <= msg_total_reg + 32'h1;
      end
   end

   // pause counted in whole microseconds from its own start, so that a
   // short gap never collapses onto the free-running tick
   always_ff @(posedge i_clk) begin
      if (i_srst || (state_reg != ST_GAP)) begin
         gap_cyc_reg <= '0;
         gap_cnt_reg <= '0;
      end else if (gap_us_end) begin
         gap_cyc_reg <= '0;
         gap_cnt_reg <= gap_cnt_reg + 32'h1;
      end else begin
         gap_cyc_reg <= 7'(gap_cyc_reg + 1'b1);
      end
   end

   // enable read in ST_RD_EN, data read (pre-advance address) in ST_RD_DATA
   // the enable value is checked one cycle later against i_reg_rdata
   // and the data value answers in the first push cycle
   logic [31:0] rd_addr;
   always_comb begin
      rd_addr = en_addr_reg;
      if (state_reg == ST_RD_DATA) begin
         rd_addr = dat_addr_reg;
      end
   end
   assign o_reg_rd = (state_reg == ST_RD_EN) || (state_reg == ST_RD_DATA);
   assign o_reg_addr = rd_addr;

   // frames go out in the same layout as individual reports
   cbr_fifo #(
      .WIDTH($bits(cbr_frame_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_in_valid(push_req),
      .o_in_ready(fifo_ready),
      .i_in_data(frame_reg),
      .o_out_valid(o_frame_valid),
      .i_out_ready(i_frame_ready),
      .o_out_data(o_frame)
   );
endmodule
`default_nettype wire

// [testbench/cbr_mapper_monitor.sv]
// port checker for the bulk report mapper
// assumes one clock domain with the synchronous high reset
`timescale 1ns/1ps
`default_nettype none
module cbr_mapper_monitor
   import cbr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_reg_rd,
   input wire logic o_frame_valid,
   input wire logic i_frame_ready,
   input wire cbr_frame_t o_frame
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire req = i_avs_read | i_avs_write;
   wire low_hole = i_avs_address >= 8'h14 && i_avs_address < ADDR_BLK_BASE;
   wire unmapped = low_hole || i_avs_address >= ADDR_BLK_END;
   sequence s_wait_one;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   sequence s_rd_two;
      o_reg_rd [*2];
   endsequence
   a_wait_first: assert property ($rose(req) |-> s_wait_one)
      else $error("request not stalled exactly one cycle");
   a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest held past one cycle");
   a_idle_free: assert property (!req |-> !o_avs_waitrequest)
      else $error("waitrequest high while idle");
   a_hole_zero: assert property (i_avs_read && !o_avs_waitrequest && unmapped
      |-> o_avs_readdata == 32'h0)
      else $error("unmapped read returned nonzero");
   a_rd_pair: assert property ($rose(o_reg_rd) |-> s_rd_two)
      else $error("enable read not followed by data read");
   a_frame_hold: assert property (o_frame_valid && !i_frame_ready
      |=> o_frame_valid && $stable(o_frame))
      else $error("frame changed while stalled");
   a_frame_dlc: assert property (o_frame_valid |-> o_frame.dlc == CAN_DLC)
      else $error("frame length code wrong");
   a_reset_quiet: assert property ($fell(i_srst) |-> !o_frame_valid && !o_reg_rd)
      else $error("activity right after reset");
endmodule
bind cbr_mapper cbr_mapper_monitor cbr_mapper_monitor_inst (
   .i_clk, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write,
   .o_avs_readdata, .o_avs_waitrequest, .o_reg_rd, .o_frame_valid,
   .i_frame_ready, .o_frame
);
`default_nettype wire

// [testbench/cbr_regspace_model.sv]
// register space and frame receiver facing the mapper
// assumes reads are answered one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module cbr_regspace_model #(
   parameter logic [31:0] ZERO_ADDR = 32'h00000300
) (
   input wire logic i_clk,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_addr,
   output logic [31:0] o_reg_rdata = 32'h0,
   input wire logic i_slow,
   output logic o_frame_ready
);
   logic [1:0] beat_reg = 2'h0;
   always @(posedge i_clk) begin
      beat_reg <= beat_reg + 2'h1;
      // idle port shows a changing pattern, never the last value
      if (i_reg_rd)
         o_reg_rdata <= (i_reg_addr == ZERO_ADDR) ? 32'h0 :
                        {8'h5a, i_reg_addr[23:0]};
      else
         o_reg_rdata <= ~o_reg_rdata;
   end
   // slow receiver accepts on half the cycles
   assign o_frame_ready = !i_slow | beat_reg[1];
endmodule
`default_nettype wire

// [testbench/cbr_mapper_bench.sv]
// self-checking bench for the bulk report mapper
// drives the settings bus, watches the frame stream
`timescale 1ns/1ps
`default_nettype none
module cbr_mapper_bench
   import cbr_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] av_addr = 8'h0;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [3:0] av_be = 4'h0;
   logic slow = 1'b0;
   logic [31:0] rdata, reg_addr, reg_rdata, rv;
   logic wait_req, reg_rd, fvalid, fready;
   cbr_frame_t frame;
   cbr_frame_t got_q[$];
   cbr_frame_t exp_q[$];
   int t_q[$];
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] st[4], sd[4], cn[4];
   logic [10:0] base;
   cbr_mapper cbr_mapper_inst (.i_clk(i_clk), .i_srst(i_srst),
      .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
      .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
      .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .i_reg_rdata(reg_rdata),
      .o_frame_valid(fvalid), .i_frame_ready(fready), .o_frame(frame));
   cbr_regspace_model #(.ZERO_ADDR(32'h00001300))
      cbr_regspace_model_inst (.i_clk(i_clk),
      .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .o_reg_rdata(reg_rdata),
      .i_slow(slow), .o_frame_ready(fready));
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (fvalid === 1'b1 && fready === 1'b1) begin
         got_q.push_back(frame);
         t_q.push_back(cyc);
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string w, input logic [47:0] e, g);
      checks_done++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", w, e, g);
         fail_count++;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge i_clk);
      av_addr <= a;
      av_wd <= d;
      av_be <= be;
      av_wr <= wr;
      av_rd <= !wr;
      do begin
         @(posedge i_clk);
      end while (wait_req !== 1'b0);
      rv = rdata;
      chk("waitrequest", 48'h0, 48'(wait_req));
      av_wr <= 1'b0;
      av_rd <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 32'h0, 4'h0);
      chk($sformatf("register %h", a), 48'(e), 48'(rv));
   endtask
   task automatic setup;
      bus(1, ADDR_BASE_ID, {21'h0, base}, 4'hf);
      for (int b = 0; b < 4; b++) begin
         bus(1, ADDR_BLK_BASE + 8'(16 * b), st[b], 4'hf);
         // enable bank sits 0x1000 above the data bank of the component
         bus(1, ADDR_BLK_BASE + 8'(16 * b + 4), st[b] | 32'h1000, 4'hf);
         bus(1, ADDR_BLK_BASE + 8'(16 * b + 8), sd[b], 4'hf);
         bus(1, ADDR_BLK_BASE + 8'(16 * b + 12), cn[b], 4'hf);
      end
   endtask
   task automatic build;
      logic [10:0] id;
      logic [31:0] a;
      id = base + BULK_ID_OFFSET;
      exp_q.delete();
      for (int b = 0; b < 4; b++) begin
         for (int i = 0; i < cn[b]; i++) begin
            a = st[b] + i * sd[b];
            if (st[b] != 32'h0 && (a | 32'h1000) != 32'h1300)
               exp_q.push_back({id, CAN_DLC, 8'h5a, a[23:0]});
            id++;
         end
      end
   endtask
   task automatic sweep(input int n);
      int k;
      int m;
      m = exp_q.size();
      k = 0;
      chk("idle frames", 48'h0, 48'(got_q.size()));
      got_q.delete();
      t_q.delete();
      bus(1, ADDR_CTRL, 32'h1, 4'hf);
      while (got_q.size() < n && k < 20000) begin
         @(posedge i_clk);
         k++;
      end
      bus(1, ADDR_CTRL, 32'h0, 4'hf);
      chk("frame count", 48'(n), 48'(got_q.size()));
      for (int j = 0; j < got_q.size() && j < n; j++) begin
         chk("frame", 48'(exp_q[j % m]), 48'(got_q[j]));
         if (j % m != 0)
            chk("gap", 48'h1, 48'(t_q[j] - t_q[j-1] >= 95));
         else if (j > 0)
            chk("period", 48'h1,
                48'(t_q[j] - t_q[j-m] inside {[4900:6100]}));
      end
   endtask
   initial begin
      int k;
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      rchk(ADDR_CTRL, 32'h0);
      rchk(ADDR_BASE_ID, {21'h0, RST_BASE_ID});
      rchk(ADDR_PERIOD, RST_PERIOD);
      rchk(ADDR_MSG_GAP, RST_MSG_GAP);
      rchk(ADDR_STATUS, 32'h0);
      for (int r = 0; r < 64; r += 4)
         rchk(ADDR_BLK_BASE + 8'(r), 32'h0);
      bus(1, 8'h20, 32'hffffffff, 4'hf);
      rchk(8'h20, UNMAPPED_DATA);
      rchk(8'h84, UNMAPPED_DATA);
      bus(1, ADDR_BLK_BASE + 8'h38, 32'hffffffff, 4'hf);
      bus(1, ADDR_BLK_BASE + 8'h38, 32'h0, 4'h1);
      rchk(ADDR_BLK_BASE + 8'h38, 32'hffffff00);
      $display("test registers done");
      bus(1, ADDR_PERIOD, 32'h32, 4'hf);
      bus(1, ADDR_MSG_GAP, 32'h1, 4'hf);
      base = 11'h100;
      st = '{32'h100, 32'h0, 32'h200, 32'h300};
      sd = '{32'h6, 32'h1, 32'h4, 32'h1};
      cn = '{32'h3, 32'h2, 32'h2, 32'h2};
      setup();
      build();
      sweep(2 * exp_q.size());
      k = got_q.size();
      repeat (7000) @(posedge i_clk);
      chk("quiet", 48'(k), 48'(got_q.size()));
      // twelve frames sent, last element not suppressed, back at block 0
      rchk(ADDR_STATUS, 32'h000000c0);
      got_q.delete();
      $display("test two sweeps done");
      base = 11'h080;
      cn[0] = 32'h10;
      cn[2] = 32'h8;
      slow <= 1'b1;
      setup();
      build();
      sweep(exp_q.size());
      $display("test shifted ids done");
      close_out();
   end
   initial begin
      repeat (60000) @(posedge i_clk);
      $display("mismatch watchdog expected end seen hang");
      fail_count++;
      close_out();
   end
endmodule
`default_nettype wire
